/* File: design/wake_pkg.sv */
// Purpose: shared constants and types for the power-down wake enable block
// Assumes: AHB-Lite word access, 32-bit data
// Notes: offsets are byte addresses
package wake_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] WAKE_EN_ADDR = 32'hE01F_C144;
  localparam logic [31:0] PMODE_ADDR = 32'hE01F_C148;
  localparam logic [31:0] CAUSE_ADDR = 32'hE01F_C14C;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int PIN_IRQ_LSB = 0;
  localparam int PIN_IRQ_MSB = 3;
  localparam int LAN_BIT = 4;
  localparam int USB_BIT = 5;
  localparam int CAN_BIT = 6;
  localparam int GPIO_BIT = 7;
  localparam int BOD_BIT = 14;
  localparam int RTC_BIT = 15;
  localparam logic [15:0] WAKE_EN_MASK = 16'hC0FF;
  localparam logic [15:0] WAKE_EN_RESET = 16'h0000;
  localparam logic [15:0] CAUSE_RESET = 16'h0000;
  localparam logic [2:0] PMODE_RESET = 3'h0;
  localparam logic [2:0] PMODE_NORMAL = 3'h0;
  localparam logic [2:0] PMODE_POWER_DOWN = 3'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_PDOWN = 3'b010,
    ST_WAKE = 3'b100
  } pwr_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
  } bus_cmd_t;

endpackage : wake_pkg

/* File: design/pin_sync3.sv */
// Purpose: three-flop synchroniser with agreement filter for pin inputs
// Assumes: inputs asynchronous to CLK_I
// Notes: output follows once second and third stage agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  wire logic [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
  wire logic [WIDTH-1:0] sync_d = (agree & s3_q) | (~agree & sync_o);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sync_o <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_o <= sync_d;
    end
  end

endmodule : pin_sync3

/* File: design/wake_ctrl.sv */
// Purpose: wake source enables and power-down exit request, AHB-Lite slave
// Assumes: 100 MHz CLK_I, active-low async reset, word accesses only
// Notes: request term is pure logic; output is registered
//
// How it works
// - pin bits 0-3 let pins wake
// - bit 4 lets LAN wake irq wake
// - bit 5: USB line change wakes
// - bit 6: CAN receive change wakes
// - bit 7: armed GPIO activity wakes
// - bit 14: brown-out irq wakes, no guarantees
// - bit 15: any RTC irq wakes
// - wake independent of interrupt controller enable
// - power-down is mode 010, clocks halted
`timescale 1ns/1ps
module wake_ctrl (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // external interrupt pins and their state
  input wire logic [3:0] EXTERNAL_IRQ_PIN_N_I,
  input wire logic [3:0] EXTERNAL_IRQ_PIN_FUNCTION_I,
  input wire logic [3:0] PIN_IRQ_PENDING_FLAGS_I,
  // other wake sources
  input wire logic LAN_WAKE_IRQ_I,
  input wire logic [1:0] USB_DATA_PIN_I,
  input wire logic [1:0] CAN_RX_PIN_I,
  input wire logic GPIO_WAKE_I,
  input wire logic BROWNOUT_IRQ_I,
  input wire logic RTC_IRQ_I,
  // power control
  output logic WAKE_REQ_O,
  output logic CLOCKS_RUN_O,
  output logic [2:0] POWER_MODE_O
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pin_n_s;
  logic [1:0] usb_s;
  logic [1:0] can_s;
  logic bod_s;
  logic rtc_s;

  pin_sync3 #(.WIDTH(10)) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .async_i({EXTERNAL_IRQ_PIN_N_I, USB_DATA_PIN_I, CAN_RX_PIN_I, BROWNOUT_IRQ_I, RTC_IRQ_I}),
    .sync_o({pin_n_s, usb_s, can_s, bod_s, rtc_s})
  );

  // ****************************************
  // bus address phase
  // ****************************************
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] off);
    addr_hit = (a[31:2] == off[31:2]);
  endfunction : addr_hit

  wake_pkg::bus_cmd_t cmd_q;
  logic wr_pend_q;
  logic [15:0] wake_en_q;
  logic [15:0] wake_en_d;
  logic [2:0] pmode_q;
  logic [2:0] pmode_d;
  logic [15:0] cause_q;
  logic [15:0] cause_d;
  logic wake_req_q;
  logic clk_run_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] usb_prev_q;
  logic [1:0] can_prev_q;
  wake_pkg::pwr_state_t st_q;
  wake_pkg::pwr_state_t st_d;

  wire logic addr_valid = HSEL_I && HREADY_I && HTRANS_I[1];
  wire logic rd_take = addr_valid && !HWRITE_I;
  wire logic wr_take = addr_valid && HWRITE_I;

  // ****************************************
  // write decode in data phase
  // ****************************************
  wire logic wr_en_reg = wr_pend_q && addr_hit(cmd_q.addr, wake_pkg::WAKE_EN_ADDR);
  wire logic wr_pmode = wr_pend_q && addr_hit(cmd_q.addr, wake_pkg::PMODE_ADDR);
  wire logic wr_cause = wr_pend_q && addr_hit(cmd_q.addr, wake_pkg::CAUSE_ADDR);

  // ****************************************
  // wake conditions
  // ****************************************
  logic [15:0] cond;
  always_comb begin
    cond = 16'h0000;
    // asserted low pin, function selected, no flag pending
    cond[wake_pkg::PIN_IRQ_MSB:wake_pkg::PIN_IRQ_LSB] =
      ~pin_n_s & EXTERNAL_IRQ_PIN_FUNCTION_I & ~PIN_IRQ_PENDING_FLAGS_I;
    cond[wake_pkg::LAN_BIT] = LAN_WAKE_IRQ_I;
    cond[wake_pkg::USB_BIT] = |(usb_s ^ usb_prev_q);
    cond[wake_pkg::CAN_BIT] = |(can_s ^ can_prev_q);
    cond[wake_pkg::GPIO_BIT] = GPIO_WAKE_I;
    cond[wake_pkg::BOD_BIT] = bod_s;
    cond[wake_pkg::RTC_BIT] = rtc_s;
  end

  // no interrupt controller enable in this path
  wire logic [15:0] hits = cond & wake_en_q;
  wire logic wake_any = |hits;
  wire logic in_pd = (st_q == wake_pkg::ST_PDOWN);
  wire logic wake_fire = in_pd && wake_any;

  // ****************************************
  // power state machine
  // ****************************************
  always_comb begin
    st_d = st_q;
    case (st_q)
      wake_pkg::ST_RUN: begin
        if (wr_pmode && HWDATA_I[2:0] == wake_pkg::PMODE_POWER_DOWN) begin
          st_d = wake_pkg::ST_PDOWN;
        end
      end
      wake_pkg::ST_PDOWN: begin
        if (wake_any) begin
          st_d = wake_pkg::ST_WAKE;
        end
      end
      wake_pkg::ST_WAKE: begin
        st_d = wake_pkg::ST_RUN;
      end
      default: begin
        st_d = wake_pkg::ST_RUN;
      end
    endcase
  end

  // ****************************************
  // register next values
  // ****************************************
  // reserved bits 13:8 never stored
  assign wake_en_d = wr_en_reg ? (HWDATA_I[15:0] & wake_pkg::WAKE_EN_MASK) : wake_en_q;

  // wake clears the mode and wins over a write
  assign pmode_d = wake_fire ? wake_pkg::PMODE_NORMAL :
                   wr_pmode ? HWDATA_I[2:0] : pmode_q;

  // cause is sticky, write one to clear, set wins
  assign cause_d = ((wr_cause ? (cause_q & ~HWDATA_I[15:0]) : cause_q) | (wake_fire ? hits : 16'h0000));

  // read path forwards the data-phase write
  assign rdata_d = !rd_take ? wake_pkg::RDATA_NONE :
                   addr_hit(HADDR_I, wake_pkg::WAKE_EN_ADDR) ? {16'h0000, wake_en_d} :
                   addr_hit(HADDR_I, wake_pkg::PMODE_ADDR) ? {29'h0000_0000, pmode_d} :
                   addr_hit(HADDR_I, wake_pkg::CAUSE_ADDR) ? {16'h0000, cause_d} :
                   wake_pkg::RDATA_NONE;

  // ****************************************
  // bus state
  // ****************************************
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= '0;
      wr_pend_q <= 1'b0;
      rdata_q <= wake_pkg::RDATA_NONE;
    end else begin
      if (HREADY_I) begin
        cmd_q <= '{addr: HADDR_I, write: HWRITE_I};
        wr_pend_q <= wr_take;
      end
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wake_en_q <= wake_pkg::WAKE_EN_RESET;
      pmode_q <= wake_pkg::PMODE_RESET;
      cause_q <= wake_pkg::CAUSE_RESET;
      st_q <= wake_pkg::ST_RUN;
    end else begin
      wake_en_q <= wake_en_d;
      pmode_q <= pmode_d;
      cause_q <= cause_d;
      st_q <= st_d;
    end
  end

  // ****************************************
  // activity history and outputs
  // ****************************************
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      usb_prev_q <= 2'h0;
      can_prev_q <= 2'h0;
      wake_req_q <= 1'b0;
      clk_run_q <= 1'b1;
    end else begin
      usb_prev_q <= usb_s;
      can_prev_q <= can_s;
      wake_req_q <= wake_fire;
      clk_run_q <= (st_d != wake_pkg::ST_PDOWN);
    end
  end

  assign HRDATA_O = rdata_q;
  // second reset flop only, first stage stays private
  assign HREADYOUT_O = rst_n;
  assign HRESP_O = 1'b0;
  assign WAKE_REQ_O = wake_req_q;
  assign CLOCKS_RUN_O = clk_run_q;
  assign POWER_MODE_O = pmode_q;

  // ****************************************
  // checks
  // ****************************************
  property p_pin_wake;
    @(posedge CLK_I) disable iff (!rst_n)
    (in_pd && |(cond[3:0] & wake_en_q[3:0])) |=> (WAKE_REQ_O && CLOCKS_RUN_O ##1 !WAKE_REQ_O && CLOCKS_RUN_O);
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("enabled pin did not wake");

  property p_lan_wake;
    @(posedge CLK_I) disable iff (!rst_n)
    (in_pd && LAN_WAKE_IRQ_I && wake_en_q[4]) |=> (WAKE_REQ_O && POWER_MODE_O == 3'h0);
  endproperty
  a_lan_wake: assert property (p_lan_wake) else $error("lan wake missed");

  property p_usb_wake;
    @(posedge CLK_I) disable iff (!rst_n)
    (in_pd && wake_en_q[5] && usb_s != $past(usb_s)) |=> WAKE_REQ_O;
  endproperty
  a_usb_wake: assert property (p_usb_wake) else $error("usb activity did not wake");

  property p_can_wake;
    @(posedge CLK_I) disable iff (!rst_n)
    (in_pd && wake_en_q[6] && can_s != $past(can_s)) |=> (WAKE_REQ_O ##1 !WAKE_REQ_O);
  endproperty
  a_can_wake: assert property (p_can_wake) else $error("can activity did not wake");

  property p_gpio_wake;
    @(posedge CLK_I) disable iff (!rst_n)
    (in_pd && GPIO_WAKE_I && wake_en_q[7]) |=> cause_q[7];
  endproperty
  a_gpio_wake: assert property (p_gpio_wake) else $error("gpio wake cause not recorded");

  property p_bod_wake;
    @(posedge CLK_I) disable iff (!rst_n)
    (in_pd && bod_s && wake_en_q[14]) |=> WAKE_REQ_O;
  endproperty
  a_bod_wake: assert property (p_bod_wake) else $error("brown-out wake missed");

  property p_rtc_wake;
    @(posedge CLK_I) disable iff (!rst_n)
    (in_pd && rtc_s && wake_en_q[15]) |=> (WAKE_REQ_O && cause_q[15]);
  endproperty
  a_rtc_wake: assert property (p_rtc_wake) else $error("rtc wake missed");

  property p_no_stray_wake;
    @(posedge CLK_I) disable iff (!rst_n)
    WAKE_REQ_O |-> ($past(in_pd) && $past(wake_any));
  endproperty
  a_no_stray_wake: assert property (p_no_stray_wake) else $error("wake without enabled source");

  property p_pd_mode;
    @(posedge CLK_I) disable iff (!rst_n)
    (in_pd && !wake_any) |=> (!CLOCKS_RUN_O && POWER_MODE_O == 3'h2);
  endproperty
  a_pd_mode: assert property (p_pd_mode) else $error("power-down not held");

  property p_reset_clear;
    @(posedge CLK_I) disable iff (!rst_n)
    $rose(rst_n) |-> (wake_en_q == 16'h0000 && !WAKE_REQ_O);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enables not clear after reset");

  property p_reserved_zero;
    @(posedge CLK_I) disable iff (!rst_n)
    wr_en_reg |=> (wake_en_q[13:8] == 6'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable bits stored");

endmodule : wake_ctrl

/* File: bench/wake_src_model.sv */
// Purpose: far-side wake sources and pin state for the wake block
// Assumes: bench drives act_i by non-blocking assignment after a rising edge
// Notes: usb and can lines move on every flip of their act bit
`timescale 1ns/1ps
module wake_src_model (
  // commands from the bench
  input wire logic [15:0] act_i,
  input wire logic pend_i,
  input wire logic fn_off_i,
  // source lines
  output logic [3:0] pin_n_o,
  output logic [3:0] fn_o,
  output logic [3:0] pend_o,
  output logic lan_o,
  output logic [1:0] usb_o,
  output logic [1:0] can_o,
  output logic gpio_o,
  output logic bod_o,
  output logic rtc_o
);
  // ****************************************
  // source levels
  // ****************************************
  assign pin_n_o = ~act_i[3:0];
  assign fn_o = fn_off_i ? 4'h6 : 4'hF;
  assign pend_o = {3'h0, pend_i};
  assign lan_o = act_i[4];
  assign usb_o = {~act_i[5], act_i[5]};
  assign can_o = {act_i[6], act_i[6]};
  assign gpio_o = act_i[7];
  assign bod_o = act_i[14];
  assign rtc_o = act_i[15];
endmodule : wake_src_model

/* File: bench/power_down_wakeup_enable_tb_top.sv */
// Purpose: self-checking bench for the wake enable block
// Assumes: zero-wait-state slave, hready looped back
// Notes: each source is tried masked and then enabled
`timescale 1ns/1ps
module power_down_wakeup_enable_tb_top;
  logic clk, rst_n, hsel, hwrite, hready, hresp, wake, run, pend, fn_off, lan, gpio, bod, rtc;
  logic [1:0] htrans, usb, can;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0] pmode;
  logic [15:0] act;
  logic [3:0] pin_n, fn, pf;
  int n_errors, checked, cyc;

  wake_src_model i_wake_src_model (.act_i(act), .pend_i(pend), .fn_off_i(fn_off), .pin_n_o(pin_n), .fn_o(fn),
    .pend_o(pf), .lan_o(lan), .usb_o(usb), .can_o(can), .gpio_o(gpio), .bod_o(bod), .rtc_o(rtc));

  wake_ctrl i_wake_ctrl (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .EXTERNAL_IRQ_PIN_N_I(pin_n), .EXTERNAL_IRQ_PIN_FUNCTION_I(fn),
    .PIN_IRQ_PENDING_FLAGS_I(pf), .LAN_WAKE_IRQ_I(lan), .USB_DATA_PIN_I(usb), .CAN_RX_PIN_I(can),
    .GPIO_WAKE_I(gpio), .BROWNOUT_IRQ_I(bod), .RTC_IRQ_I(rtc), .WAKE_REQ_O(wake), .CLOCKS_RUN_O(run),
    .POWER_MODE_O(pmode));

  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= wake_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic bw(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, a, wd, rd);
  endtask : bw

  task automatic wait_wake(output logic got);
    got = 1'b0;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk);
      if (wake === 1'b1) begin
        got = 1'b1;
        check("mode at wake", {29'h0, pmode}, 32'h0000_0000);
        @(posedge clk);
        check("wake pulse end", {31'h0, wake}, 32'h0000_0000);
        check("clocks after wake", {31'h0, run}, 32'h0000_0001);
      end
    end
  endtask : wait_wake

  task automatic enter_pd();
    bw(wake_pkg::PMODE_ADDR, 32'h0000_0002);
    @(posedge clk);
    check("clocks in pd", {31'h0, run}, 32'h0000_0000);
    check("mode in pd", {29'h0, pmode}, {29'h0, wake_pkg::PMODE_POWER_DOWN});
  endtask : enter_pd

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] rd;
    logic got;
    check("clocks after reset", {31'h0, run}, 32'h0000_0001);
    bus(1'b0, wake_pkg::WAKE_EN_ADDR, 32'h0, rd);
    check("enable reset", rd, {16'h0, wake_pkg::WAKE_EN_RESET});
    bus(1'b0, wake_pkg::PMODE_ADDR, 32'h0, rd);
    check("mode reset", rd, 32'h0000_0000);
    bw(wake_pkg::WAKE_EN_ADDR, {16'h0, wake_pkg::WAKE_EN_MASK});
    bus(1'b0, wake_pkg::WAKE_EN_ADDR, 32'h0, rd);
    check("enable readback", rd, 32'h0000_C0FF);
    bus(1'b0, wake_pkg::WAKE_EN_ADDR + 32'h0000_0010, 32'h0, rd);
    check("unmapped read", rd, wake_pkg::RDATA_NONE);
    check("resp okay", {31'h0, hresp}, 32'h0000_0000);
    act[4] <= 1'b1;
    wait_wake(got);
    check("wake outside pd", {31'h0, got}, 32'h0000_0000);
    act <= 16'h0000;
    bus(1'b0, wake_pkg::CAUSE_ADDR, 32'h0, rd);
    check("cause outside pd", rd, 32'h0000_0000);
  endtask : t_regs

  task automatic t_sources();
    int bits [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 14, 15};
    logic [31:0] rd;
    logic got;
    foreach (bits[i]) begin
      bw(wake_pkg::WAKE_EN_ADDR, {16'h0, wake_pkg::WAKE_EN_MASK & ~(16'h0001 << bits[i])});
      enter_pd();
      act[bits[i]] <= 1'b1;
      wait_wake(got);
      check("masked source", {31'h0, got}, 32'h0000_0000);
      bw(wake_pkg::WAKE_EN_ADDR, 32'h0000_0001 << bits[i]);
      if (bits[i] == 5 || bits[i] == 6) act[bits[i]] <= 1'b0;
      wait_wake(got);
      check("enabled source", {31'h0, got}, 32'h0000_0001);
      bus(1'b0, wake_pkg::CAUSE_ADDR, 32'h0, rd);
      check("cause", rd, 32'h0000_0001 << bits[i]);
      act <= 16'h0000;
      bw(wake_pkg::CAUSE_ADDR, 32'h0000_FFFF);
    end
  endtask : t_sources

  task automatic t_pin_block();
    logic got;
    bw(wake_pkg::WAKE_EN_ADDR, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      pend <= (k == 0);
      fn_off <= (k == 1);
      enter_pd();
      act[0] <= 1'b1;
      wait_wake(got);
      check("blocked pin", {31'h0, got}, 32'h0000_0000);
      pend <= 1'b0;
      fn_off <= 1'b0;
      wait_wake(got);
      check("unblocked pin", {31'h0, got}, 32'h0000_0001);
      act <= 16'h0000;
      bw(wake_pkg::CAUSE_ADDR, 32'h0000_FFFF);
    end
  endtask : t_pin_block

  // ****************************************
  // run control
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    act = 16'h0000;
    pend = 1'b0;
    fn_off = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_sources();
    t_pin_block();
    summarize();
  end
endmodule : power_down_wakeup_enable_tb_top
